// [src/serial_link_powerdown_seq.sv]
/*
 * Power-down and clock-start sequencer for a forwarded-clock serial link,
 * with a seven-bit-per-lane serializer fed through a two-entry buffer and
 * a matching deserializer whose outputs obey power-down and clock loss.
 * Assumes the link clocks are far slower than clk (at least 16 clk cycles
 * per link period) and that every link pin is asynchronous to clk.
 */
// How it works
// - Each lane bit lasts one seventh period
// - Release with clock resets, then locks
// - Outputs toggle 10 ms after release
// - Power-down accepted any time, enters idle
// - Receiver holds outputs when clocks stop
// - Receiver outputs low during power-down
`timescale 1ns/1ps

module serial_link_powerdown_seq #(
    parameter int STARTUP_CYCLES = link_seq_pkg::STARTUP_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic power_down_n,
    input wire logic tx_clock_input,
    input wire logic in_valid,
    output logic in_ready,
    input wire link_seq_pkg::word_t in_data,
    output logic [link_seq_pkg::LANES-1:0] tx_lanes,
    output logic tx_clock_out,
    output logic link_active,
    input wire logic rx_clock_input,
    input wire logic [link_seq_pkg::LANES-1:0] rx_lanes,
    output link_seq_pkg::word_t receiver_data_outputs
);

    link_seq_pkg::state_s r_reg;
    link_seq_pkg::state_s r_next;
    logic tx_rise;
    logic rx_rise;
    logic clk_ok;
    logic tx_strobe;
    logic rx_strobe;
    logic pop;
    logic push;

    // Edge finding on the synchronised link clocks
    assign tx_rise = r_reg.sync.tx_clk & ~r_reg.tx_clk_d;
    assign rx_rise = r_reg.sync.rx_clk & ~r_reg.rx_clk_d;
    assign clk_ok = r_reg.tx_tmr < link_seq_pkg::LOSS_CYCLES;
    assign tx_strobe = (r_reg.tx_acc + link_seq_pkg::ACC_STEP) >= {1'b0, r_reg.tx_per};
    assign rx_strobe = (r_reg.rx_acc + link_seq_pkg::ACC_STEP) >= {1'b0, r_reg.rx_per};

    // Buffer handshake; words are only taken once the link runs
    assign in_ready = (r_reg.state == link_seq_pkg::ST_RUN) &&
        (r_reg.fifo_cnt != link_seq_pkg::FIFO_DEPTH);
    assign push = in_valid & in_ready;
    assign pop = (r_reg.state == link_seq_pkg::ST_RUN) && tx_rise && (r_reg.fifo_cnt != 2'h0);

    assign tx_lanes = r_reg.lanes;
    assign tx_clock_out = r_reg.clk_out;
    assign link_active = (r_reg.state == link_seq_pkg::ST_RUN);
    assign receiver_data_outputs = r_reg.rx_out;

    // Whole next state of the block
    always_comb
    begin
        logic [1:0] c;
        c = r_reg.fifo_cnt;
        r_next = r_reg;
        // Two-stage synchronisers; meta is read only by sync
        r_next.meta = '{pd_n: power_down_n, tx_clk: tx_clock_input,
            rx_clk: rx_clock_input, rx_lane: rx_lanes};
        r_next.sync = r_reg.meta;
        r_next.tx_clk_d = r_reg.sync.tx_clk;
        r_next.rx_clk_d = r_reg.sync.rx_clk;

        // Input clock period measurement, saturating so loss is visible
        if (tx_rise)
        begin
            r_next.tx_tmr = 16'h0;
            // A saturated timer means no valid period yet
            r_next.tx_per = (r_reg.tx_tmr == 16'hffff) ? 16'hffff : 16'(r_reg.tx_tmr + 16'h1);
        end
        else if (r_reg.tx_tmr != 16'hffff)
        begin
            r_next.tx_tmr = 16'(r_reg.tx_tmr + 16'h1);
        end

        // Sequencer
        unique case (r_reg.state)
            link_seq_pkg::ST_PD:
            begin
                // Internal reset of the transmit path on every entry
                r_next.startup = 22'h0;
                r_next.edges = 3'h0;
                r_next.fifo_cnt = 2'h0;
                c = 2'h0;
                if (r_reg.sync.pd_n && clk_ok)
                begin
                    r_next.state = link_seq_pkg::ST_LOCK;
                end
            end
            link_seq_pkg::ST_LOCK:
            begin
                // Delay only runs while the input clock keeps coming
                r_next.startup = 22'(r_reg.startup + 22'h1);
                if (tx_rise && r_reg.edges != link_seq_pkg::LOCK_EDGES)
                begin
                    r_next.edges = 3'(r_reg.edges + 3'h1);
                end
                if (!clk_ok)
                begin
                    r_next.state = link_seq_pkg::ST_PD;
                end
                else if (r_reg.startup >= 22'(STARTUP_CYCLES - 1) &&
                    r_reg.edges == link_seq_pkg::LOCK_EDGES)
                begin
                    r_next.state = link_seq_pkg::ST_RUN;
                end
            end
            link_seq_pkg::ST_RUN:
            begin
                r_next.state = link_seq_pkg::ST_RUN;
            end
        endcase
        // Power-down wins from any state at any time
        if (!r_reg.sync.pd_n)
        begin
            r_next.state = link_seq_pkg::ST_PD;
        end

        // Serializer: word loaded on the clock edge, then seven slots
        if (tx_rise)
        begin
            r_next.tx_word = pop ? r_reg.buf0 : '0;
            r_next.tx_bit = 3'h0;
            r_next.tx_acc = 17'h0;
        end
        else if (tx_strobe && r_reg.tx_bit != link_seq_pkg::LAST_BIT)
        begin
            r_next.tx_bit = 3'(r_reg.tx_bit + 3'h1);
            r_next.tx_acc = 17'(r_reg.tx_acc + link_seq_pkg::ACC_STEP - {1'b0, r_reg.tx_per});
        end
        else if (!tx_strobe)
        begin
            r_next.tx_acc = 17'(r_reg.tx_acc + link_seq_pkg::ACC_STEP);
        end

        // Buffer: pop shifts entry 1 down, push fills the first free slot
        if (pop)
        begin
            r_next.buf0 = r_reg.buf1;
            c = 2'(c - 2'h1);
        end
        if (push)
        begin
            if (c == 2'h0)
            begin
                r_next.buf0 = in_data;
            end
            else
            begin
                r_next.buf1 = in_data;
            end
            c = 2'(c + 2'h1);
        end
        r_next.fifo_cnt = c;

        // Lanes and forwarded clock stay low until the link runs
        for (int l = 0; l < link_seq_pkg::LANES; l++)
        begin
            r_next.lanes[l] = (r_reg.state == link_seq_pkg::ST_RUN) &&
                r_next.tx_word[l * link_seq_pkg::BITS_PER_LANE + int'(r_next.tx_bit)];
        end
        r_next.clk_out = (r_reg.state == link_seq_pkg::ST_RUN) && r_reg.sync.tx_clk;

        // Deserializer: first sample on the cycle after the edge, about one
        // cycle into slot 0, as clock and lanes share one synchroniser delay;
        // starting from zero would land every sample a slot late
        if (rx_rise)
        begin
            r_next.rx_tmr = 16'h0;
            r_next.rx_per = (r_reg.rx_tmr == 16'hffff) ? 16'hffff : 16'(r_reg.rx_tmr + 16'h1);
            r_next.rx_acc = {1'b0, r_reg.rx_tmr};
            r_next.rx_bit = 4'h0;
            if (r_reg.rx_bit == link_seq_pkg::RX_FULL)
            begin
                r_next.rx_out = r_reg.rx_shift;
            end
        end
        else
        begin
            if (r_reg.rx_tmr != 16'hffff)
            begin
                r_next.rx_tmr = 16'(r_reg.rx_tmr + 16'h1);
            end
            if (rx_strobe && r_reg.rx_bit != link_seq_pkg::RX_FULL)
            begin
                for (int l = 0; l < link_seq_pkg::LANES; l++)
                begin
                    r_next.rx_shift[l * link_seq_pkg::BITS_PER_LANE + int'(r_reg.rx_bit)] =
                        r_reg.sync.rx_lane[l];
                end
                r_next.rx_bit = 4'(r_reg.rx_bit + 4'h1);
                r_next.rx_acc = 17'(r_reg.rx_acc + link_seq_pkg::ACC_STEP -
                    {1'b0, r_reg.rx_per});
            end
            else if (!rx_strobe)
            begin
                r_next.rx_acc = 17'(r_reg.rx_acc + link_seq_pkg::ACC_STEP);
            end
        end
        // No edge means no update: outputs hold when clocks stop
        if (!r_reg.sync.pd_n)
        begin
            r_next.rx_out = '0;
        end
    end

    // Single state register, synchronous reset
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    slot_range_a: assert property (tx_rise |=> r_reg.tx_bit == 3'h0 ##1 r_reg.tx_bit <= 3'h1)
        else $error("serial slot did not restart at clock edge");
    lock_reset_a: assert property ((r_reg.state == link_seq_pkg::ST_PD &&
        r_next.state == link_seq_pkg::ST_LOCK) |=>
        r_reg.startup == 22'h0 ##1 r_reg.startup == 22'h1)
        else $error("startup count not cleared on release");
    startup_wait_a: assert property ($rose(link_active) |->
        $past(r_reg.startup) >= 22'(STARTUP_CYCLES - 1))
        else $error("link ran before startup delay");
    pd_enter_a: assert property (!r_reg.sync.pd_n |=> !link_active ##1 !tx_clock_out)
        else $error("power-down did not stop the link");
    lanes_quiet_a: assert property (!link_active |=> tx_lanes == '0 && !tx_clock_out)
        else $error("serial outputs active before run");
    rx_low_a: assert property (!r_reg.sync.pd_n |=> receiver_data_outputs == '0)
        else $error("receiver outputs not low in power-down");
    rx_hold_a: assert property ((r_reg.sync.pd_n && !rx_rise) |=>
        receiver_data_outputs == $past(receiver_data_outputs))
        else $error("receiver outputs changed without clock");

    run_reached_c: cover property ($rose(link_active));
    buffer_full_c: cover property (link_active && !in_ready);
    rx_word_c: cover property (rx_rise && r_reg.rx_bit == link_seq_pkg::RX_FULL);

endmodule // serial_link_powerdown_seq

// [src/link_seq_pkg.sv]
/*
 * Shared constants and types for the forwarded-clock serial link sequencer:
 * lane geometry, timing counts, sequencer states, synchroniser pins and the
 * whole register state of the block.
 * Assumes a 200 MHz system clock; all link pins are asynchronous to it.
 */
package link_seq_pkg;

    // Link geometry
    localparam int LANES = 4;
    localparam int BITS_PER_LANE = 7;
    localparam int WORD_W = LANES * BITS_PER_LANE;
    localparam logic [2:0] LAST_BIT = 3'h6;
    localparam logic [3:0] RX_FULL = 4'h7;

    // Timing, figures in their own units
    localparam int CLK_NS = 5;
    localparam int STARTUP_NS = 10_000_000;
    localparam int STARTUP_CYCLES = STARTUP_NS / CLK_NS;
    localparam int LOSS_NS = 2560;
    localparam logic [15:0] LOSS_CYCLES = 16'(LOSS_NS / CLK_NS);
    localparam logic [2:0] LOCK_EDGES = 3'h4;

    // Phase accumulator step: one bit slot is one seventh of a period
    localparam logic [16:0] ACC_STEP = 17'h7;

    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    typedef logic [WORD_W-1:0] word_t;

    typedef enum logic [1:0] {
        ST_PD,
        ST_LOCK,
        ST_RUN
    } seq_e;

    typedef struct packed {
        logic pd_n;
        logic tx_clk;
        logic rx_clk;
        logic [LANES-1:0] rx_lane;
    } pins_s;

    typedef struct packed {
        pins_s meta;
        pins_s sync;
        logic tx_clk_d;
        logic rx_clk_d;
        seq_e state;
        logic [21:0] startup;
        logic [2:0] edges;
        logic [15:0] tx_tmr;
        logic [15:0] tx_per;
        logic [16:0] tx_acc;
        logic [2:0] tx_bit;
        word_t tx_word;
        logic [LANES-1:0] lanes;
        logic clk_out;
        word_t buf0;
        word_t buf1;
        logic [1:0] fifo_cnt;
        logic [15:0] rx_tmr;
        logic [15:0] rx_per;
        logic [16:0] rx_acc;
        logic [3:0] rx_bit;
        word_t rx_shift;
        word_t rx_out;
    } state_s;

endpackage

// [verif/far_serializer.sv]
/*
 * Far-side serializer model driving the block's receive pins.
 * Assumes run changes only between frames; 80 ns link period.
 */
`timescale 1ns/1ps
module far_serializer (
    input wire logic run,
    input wire link_seq_pkg::word_t word,
    output logic rx_clk,
    output logic [link_seq_pkg::LANES-1:0] rx_lanes
);
    // Seven slots per period, slot 0 first; clock stands still when idle
    initial
    begin
        rx_clk = 1'b0;
        rx_lanes = 4'h0;
        forever
        begin
            wait (run);
            for (int k = 0; k < 7; k++)
            begin
                rx_clk = (k < 4);
                for (int l = 0; l < link_seq_pkg::LANES; l++)
                    rx_lanes[l] = word[l * 7 + k];
                #(80.0 / 7.0);
            end
            // Released lanes must not show stale data
            if (!run)
                rx_lanes = ~rx_lanes;
        end
    end
endmodule // far_serializer

// [verif/serial_link_powerdown_seq_tb.sv]
/*
 * Self-checking bench: startup timing, slot width, buffer back-pressure,
 * receive hold on clock loss and power-down. Assumes shortened startup.
 */
`timescale 1ns/1ps
module serial_link_powerdown_seq_tb;
    localparam int SU = 200;
    logic clk, rstn, power_down_n, tx_clock_input, tx_run, in_valid, in_ready;
    logic tx_clock_out, link_active, rx_clock_input, rx_run;
    logic [link_seq_pkg::LANES-1:0] tx_lanes, rx_lanes;
    link_seq_pkg::word_t in_data, rx_word, receiver_data_outputs;
    int error_cnt, num_checks, cycles;

    serial_link_powerdown_seq #(.STARTUP_CYCLES(SU)) dut (
        .clk(clk),
        .rstn(rstn),
        .power_down_n(power_down_n),
        .tx_clock_input(tx_clock_input),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_data),
        .tx_lanes(tx_lanes),
        .tx_clock_out(tx_clock_out),
        .link_active(link_active),
        .rx_clock_input(rx_clock_input),
        .rx_lanes(rx_lanes),
        .receiver_data_outputs(receiver_data_outputs)
    );

    far_serializer partner (
        .run(rx_run),
        .word(rx_word),
        .rx_clk(rx_clock_input),
        .rx_lanes(rx_lanes)
    );

    // System clock, then a gated link clock of unrelated phase
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        tx_clock_input = 1'b0;
        #1.7;
        forever #40 tx_clock_input = tx_run & ~tx_clock_input;
    end

    // Hang guard, far above the few thousand cycles needed
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic check_flag(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_word(input string what, input link_seq_pkg::word_t exp,
                              input link_seq_pkg::word_t got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Release power-down with the clock running; time the startup
    task automatic start_link();
        int n;
        logic quiet;
        n = 0;
        quiet = 1'b1;
        tx_run = 1'b1;
        repeat (100) @(negedge clk);
        power_down_n = 1'b1;
        while (link_active !== 1'b1 && n < SU + 50)
        begin
            @(negedge clk);
            n++;
            if (link_active !== 1'b1 && (tx_lanes !== 4'h0 || tx_clock_out !== 1'b0))
                quiet = 1'b0;
        end
        check_flag("startup_quiet", 1'b1, quiet);
        check_flag("startup_time", 1'b1, logic'(n >= SU && n <= SU + 6));
    endtask

    // Three back-to-back words; only the last carries 1010101 per lane
    task automatic tx_burst();
        int acc, n, rises, first, last;
        logic low_seen, lockstep, prev, fwd_seen;
        acc = 0;
        n = 0;
        rises = 0;
        first = 0;
        last = 0;
        low_seen = 1'b0;
        lockstep = 1'b1;
        fwd_seen = 1'b0;
        in_data = 28'h0;
        in_valid = 1'b1;
        while (acc < 3 && n < 100)
        begin
            if (in_ready === 1'b1)
                acc++;
            else
                low_seen = 1'b1;
            @(negedge clk);
            n++;
            in_data = (acc == 2) ? {4{7'h55}} : 28'h0;
        end
        in_valid = 1'b0;
        check_flag("ready_drops_full", 1'b1, low_seen);
        // Previous lane level kept by hand between falling edges
        prev = tx_lanes[0];
        for (int c = 0; c < 150; c++)
        begin
            @(negedge clk);
            if (tx_clock_out === 1'b1)
                fwd_seen = 1'b1;
            if (tx_lanes !== {4{tx_lanes[0]}})
                lockstep = 1'b0;
            if (tx_lanes[0] === 1'b1 && prev !== 1'b1)
            begin
                rises++;
                if (rises == 1)
                    first = c;
            end
            if (tx_lanes[0] === 1'b0 && prev === 1'b1)
                last = c;
            prev = tx_lanes[0];
        end
        check_flag("lane_lockstep", 1'b1, lockstep);
        check_flag("fwd_clock_runs", 1'b1, fwd_seen);
        check_flag("slot_count", 1'b1, logic'(rises == 4));
        check_flag("slot_width", 1'b1, logic'(last - first >= 15 && last - first <= 17));
    endtask

    // Receive a word, stop the far clock, outputs must hold
    task automatic rx_hold();
        rx_word = 28'h9a5c3e1;
        rx_run = 1'b1;
        repeat (100) @(negedge clk);
        rx_run = 1'b0;
        repeat (100) @(negedge clk);
        check_word("rx_word", 28'h9a5c3e1, receiver_data_outputs);
        repeat (600) @(negedge clk);
        check_word("rx_held", 28'h9a5c3e1, receiver_data_outputs);
    endtask

    // Power-down in mid-run, then stop the clock
    task automatic power_off();
        power_down_n = 1'b0;
        repeat (6) @(negedge clk);
        check_flag("active_after_pd", 1'b0, link_active);
        check_flag("clock_after_pd", 1'b0, tx_clock_out);
        check_word("rx_after_pd", 28'h0, receiver_data_outputs);
        tx_run = 1'b0;
        repeat (300) @(negedge clk);
    endtask

    // Main sequence; second startup restarts the full count
    initial
    begin
        rstn = 1'b0;
        power_down_n = 1'b0;
        tx_run = 1'b0;
        in_valid = 1'b0;
        in_data = 28'h0;
        rx_run = 1'b0;
        rx_word = 28'h0;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        check_flag("active_in_pd", 1'b0, link_active);
        check_word("rx_in_pd", 28'h0, receiver_data_outputs);
        start_link();
        tx_burst();
        rx_hold();
        power_off();
        start_link();
        give_verdict();
    end
endmodule // serial_link_powerdown_seq_tb
